// File: common/cel_regs.vh
`ifndef CEL_REGS_VH
`define CEL_REGS_VH

// register byte offsets
`define CEL_OFS_CTRL 10'h000
`define CEL_OFS_SETUP 10'h004
`define CEL_OFS_ALARM 10'h008
`define CEL_OFS_STOP 10'h00C
`define CEL_OFS_ERRCODE 10'h010
`define CEL_OFS_STATUS 10'h014
`define CEL_OFS_LOG 10'h100

// control word fields
`define CEL_CTRL_RUN_REQ 0
`define CEL_CTRL_MONITOR 1
`define CEL_CTRL_OUT_OFF 2
`define CEL_CTRL_IOM_HOLD 3
`define CEL_CTRL_PWROFF_INT_EN 4
`define CEL_CTRL_LOG_PTR_RST 14
`define CEL_CTRL_RST_VAL 5'h00

// setup word 83 image, bit 15 startup condition
`define CEL_SETUP_NOWAIT 15
`define CEL_SETUP_RST_VAL 16'h0000

// status word fields
`define CEL_STAT_STATE_LSB 0
`define CEL_STAT_COUNT_LSB 8
`define CEL_STAT_NONFATAL 13
`define CEL_STAT_TOOL_EN 14

// error log geometry
`define CEL_LOG_RECORDS 20
`define CEL_LOG_WORDS 5

// error code bases
`define CEL_CODE_ALARM_BASE 16'h4100
`define CEL_CODE_STOP_BASE 16'hC100
`define CEL_CODE_BUS_UNIT 16'h0200
`define CEL_CODE_SPECIAL_UNIT 16'h0300
`define CEL_CODE_BUS_SET 16'h0400
`define CEL_CODE_SPECIAL_SET 16'h0500
`define CEL_CODE_BATTERY 16'h00F7

// error categories held in record word 4
`define CEL_CAT_NONFATAL 16'h0001
`define CEL_CAT_FATAL 16'h0002

// error lamp flash timing
`define CEL_CLK_MHZ 100
`define CEL_BLINK_HALF_MS 500
`define CEL_BLINK_HALF_CYC (`CEL_BLINK_HALF_MS * 1000 * `CEL_CLK_MHZ)

`endif

// File: rtl/cel_log_store.v
`timescale 1ns/10ps
`default_nettype none

module cel_log_store #(
   parameter RECORDS = 20,
   parameter WORDS = 5
) (
   input wire clk_sys,
   input wire rstn,
   input wire push,
   input wire clearPtr,
   input wire [16*WORDS-1:0] record,
   input wire [6:0] rdIndex,
   output reg [15:0] rdData,
   output reg [4:0] count
);
   localparam TOTAL = RECORDS * WORDS;

   reg [15:0] mem [0:TOTAL-1];
   integer i;

   // newest record sits at words 0..4, oldest falls off the end
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < TOTAL; i = i + 1) begin
            mem[i] <= 16'h0000;
         end
      end else if (push) begin
         for (i = TOTAL - 1; i >= WORDS; i = i - 1) begin
            mem[i] <= mem[i - WORDS]; // [RULE23] [RULE5]
         end
         for (i = 0; i < WORDS; i = i + 1) begin
            mem[i] <= record[16*i +: 16]; // [RULE1]
         end
      end
   end

   // pointer reset leaves the stored words alone
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count <= 5'h00;
      end else if (clearPtr) begin
         count <= push ? 5'h01 : 5'h00; // [RULE6]
      end else if (push && (count < RECORDS[4:0])) begin
         count <= count + 5'h01; // [RULE1]
      end
   end

   always @* begin
      rdData = 16'h0000;
      if (rdIndex < TOTAL[6:0]) begin
         rdData = mem[rdIndex];
      end
   end
endmodule // cel_log_store

`default_nettype wire

// File: rtl/cel_lamp_ctrl.v
`timescale 1ns/10ps
`default_nettype none

module cel_lamp_ctrl #(
   parameter [31:0] BLINK_HALF_CYC = 32'd50000000
) (
   input wire clk_sys,
   input wire rstn,
   input wire inRun,
   input wire inFatal,
   input wire inCpuErr,
   input wire inReset,
   input wire nonFatal,
   input wire outOff,
   input wire toolCommErr,
   input wire serialCommErr,
   output reg runLamp,
   output reg errorLamp,
   output reg outputInhibitLamp,
   output reg toolPortLamp,
   output reg serialPortLamp
);
   reg [31:0] blinkCount;
   reg blink;
   wire dark = inCpuErr | inReset;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         blinkCount <= 32'h0;
         blink <= 1'b0;
      end else if (blinkCount >= BLINK_HALF_CYC - 32'h1) begin
         blinkCount <= 32'h0;
         blink <= ~blink;
      end else begin
         blinkCount <= blinkCount + 32'h1;
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {runLamp, errorLamp, outputInhibitLamp, toolPortLamp, serialPortLamp} <= 5'h00;
      end else begin
         runLamp <= inRun; // [RULE8] [RULE9] [RULE10]
         if (inCpuErr || inFatal) begin
            errorLamp <= 1'b1; // [RULE9] [RULE11] [RULE12]
         end else if (inRun && nonFatal) begin
            errorLamp <= blink; // [RULE8]
         end else begin
            errorLamp <= 1'b0; // [RULE10] [RULE13]
         end
         outputInhibitLamp <= outOff & ~dark; // [RULE8] [RULE13]
         toolPortLamp <= ~dark & ~toolCommErr; // [RULE8]
         serialPortLamp <= ~dark & ~serialCommErr; // [RULE8]
      end
   end
endmodule // cel_lamp_ctrl

`default_nettype wire

// File: rtl/cel_error_log.v
// Behaviour
// RULE1: each error logs code, contents and time; at most 20 records. Only the most serious error of a cycle is logged.
// RULE2: user alarm n (1..511) logs non-fatal code 4100h plus n.
// RULE3: user stop n (1..511) logs fatal code C100h plus n.
// RULE4: user alarm lets execution go on; user stop halts it.
// RULE5: when full, oldest record drops; newest goes to first slot.
// RULE6: log pointer reset empties the log view, keeps record contents.
// RULE7: simultaneous errors put only the most serious code in the code word.
// RULE8: non-fatal: running, run lamp on, error lamp flashes, other lamps live.
// RULE9: fatal: stopped, run lamp off, error lamp steady.
// RULE10: standby: not running, run and error lamps off.
// RULE11: watchdog failure: stopped, error lamp on, no tool, no logging.
// RULE12: fatal error lamps as watchdog failure, but tool still accepted; output-off and port lamps stay live in fatal, dark on watchdog.
// RULE13: reset state: stopped, lamps off, no tool, no logging.
// RULE14: reset state on rack unpowered, control unit miswired or cable reversed.
// RULE15: rack power loss halts program, raises power-off interrupt if enabled.
// RULE16: rack power return runs full startup instead of resuming.
// RULE17: startup in run mode waits in standby until all units detected.
// RULE18: standby when a bus unit fails to start or a unit is missing.
// RULE19: setup word 83 bit 15 chooses wait for units (0) or no wait (1).
// RULE20: unit and battery faults log non-fatal codes with unit number; the battery code 00F7h is logged with no unit number.
// RULE21: unit setting faults log non-fatal codes carrying the unit number.
// RULE22: fatal other than user stop clears memory, or on hold forces outputs off.
// RULE23: records are five words; insert shifts all records one slot atomically.
`timescale 1ns/10ps
`default_nettype none
`include "cel_regs.vh"

module cel_error_log #(
   parameter [31:0] BLINK_HALF_CYC = `CEL_BLINK_HALF_CYC
) (
   input wire clk_sys,
   input wire rstn,
   input wire [9:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire rackPowerLost,
   input wire ioCtrlMiswired,
   input wire rackCableReversed,
   input wire watchdogExpired,
   input wire unitsDetected,
   input wire busUnitStartFail,
   input wire specialUnitMissing,
   input wire busUnitErr,
   input wire specialUnitErr,
   input wire busUnitSetErr,
   input wire specialUnitSetErr,
   input wire [7:0] unitNum,
   input wire batteryErr,
   input wire fatalSysErr,
   input wire [15:0] fatalSysCode,
   input wire toolCommErr,
   input wire serialCommErr,
   output wire runLamp,
   output wire errorLamp,
   output wire outputInhibitLamp,
   output wire toolPortLamp,
   output wire serialPortLamp,
   output reg programRun,
   output reg toolConnectEnable,
   output reg powerOffIrq,
   output reg ioMemClear,
   output reg outputsForcedOff
);
   localparam ST_RESET = 5'h01;
   localparam ST_STANDBY = 5'h02;
   localparam ST_RUN = 5'h04;
   localparam ST_FATAL = 5'h08;
   localparam ST_CPUERR = 5'h10;

   function [15:0] numCode;
      input [15:0] base;
      input [8:0] num;
      begin
         numCode = base + {7'h00, num};
      end
   endfunction

   function [31:0] beMerge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] be;
      integer k;
      begin
         beMerge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               beMerge[8*k +: 8] = data[8*k +: 8];
            end
         end
      end
   endfunction

   // pin synchronisers: stage A feeds only stage B
   reg [3:0] pinSyncA;
   reg [3:0] pinSyncB;
   reg rackLostPrev;
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pinSyncA <= 4'h0;
         pinSyncB <= 4'h0;
         rackLostPrev <= 1'b0;
      end else begin
         pinSyncA <= {watchdogExpired, rackCableReversed, ioCtrlMiswired, rackPowerLost};
         pinSyncB <= pinSyncA;
         rackLostPrev <= pinSyncB[0];
      end
   end
   wire rackLost = pinSyncB[0];
   wire resetCause = pinSyncB[0] | pinSyncB[1] | pinSyncB[2]; // [RULE14]
   wire wdogFail = pinSyncB[3];

   // bus handshake: one wait cycle, then the transfer completes
   wire busReq = avs_read | avs_write;
   wire busDone = busReq & ~avs_waitrequest;
   wire wrDone = avs_write & busDone;
   wire [7:0] wordAddr = avs_address[9:2];

   reg [4:0] ctrl;
   reg [15:0] setup;
   reg [15:0] errCode;
   reg nonFatalPend;
   reg fatalByStop;
   reg [4:0] state;
   reg [4:0] next_state;
   reg [31:0] timeStamp;

   wire wrCtrl = wrDone && (wordAddr == `CEL_OFS_CTRL >> 2);
   wire wrSetup = wrDone && (wordAddr == `CEL_OFS_SETUP >> 2);
   wire wrAlarm = wrDone && (wordAddr == `CEL_OFS_ALARM >> 2) && (&avs_byteenable[1:0]);
   wire wrStop = wrDone && (wordAddr == `CEL_OFS_STOP >> 2) && (&avs_byteenable[1:0]);
   wire wrErrClr = wrDone && (wordAddr == `CEL_OFS_ERRCODE >> 2);
   wire [31:0] ctrlNew = beMerge({27'h0, ctrl}, avs_writedata, avs_byteenable);
   wire logPtrRst = wrCtrl && ctrlNew[`CEL_CTRL_LOG_PTR_RST]; // [RULE6]

   wire [8:0] instrNum = avs_writedata[8:0];
   wire alarmEvt = wrAlarm && (instrNum != 9'h000); // [RULE2]
   wire stopEvt = wrStop && (instrNum != 9'h000); // [RULE3]

   // pick the most serious of the errors raised this cycle
   reg anyEvt;
   reg bestFatal;
   reg [15:0] bestCode;
   reg [15:0] bestInfo;
   always @* begin
      anyEvt = 1'b0;
      bestFatal = 1'b0;
      bestCode = 16'h0000;
      bestInfo = 16'h0000;
      if (batteryErr) begin
         anyEvt = 1'b1;
         bestCode = `CEL_CODE_BATTERY; // [RULE20]
      end
      if (busUnitErr && numCode(`CEL_CODE_BUS_UNIT, {5'h00, unitNum[3:0]}) >= bestCode) begin
         anyEvt = 1'b1;
         bestCode = numCode(`CEL_CODE_BUS_UNIT, {5'h00, unitNum[3:0]}); // [RULE20]
         bestInfo = {8'h00, unitNum};
      end
      if (specialUnitErr && numCode(`CEL_CODE_SPECIAL_UNIT, {1'b0, unitNum}) >= bestCode) begin
         anyEvt = 1'b1;
         bestCode = numCode(`CEL_CODE_SPECIAL_UNIT, {1'b0, unitNum}); // [RULE20]
         bestInfo = {8'h00, unitNum};
      end
      if (busUnitSetErr && numCode(`CEL_CODE_BUS_SET, {5'h00, unitNum[3:0]}) >= bestCode) begin
         anyEvt = 1'b1;
         bestCode = numCode(`CEL_CODE_BUS_SET, {5'h00, unitNum[3:0]}); // [RULE21]
         bestInfo = {8'h00, unitNum};
      end
      if (specialUnitSetErr && numCode(`CEL_CODE_SPECIAL_SET, {1'b0, unitNum}) >= bestCode) begin
         anyEvt = 1'b1;
         bestCode = numCode(`CEL_CODE_SPECIAL_SET, {1'b0, unitNum}); // [RULE21]
         bestInfo = {8'h00, unitNum};
      end
      if (alarmEvt && numCode(`CEL_CODE_ALARM_BASE, instrNum) >= bestCode) begin
         anyEvt = 1'b1;
         bestCode = numCode(`CEL_CODE_ALARM_BASE, instrNum); // [RULE2] [RULE7]
         bestInfo = {7'h00, instrNum};
      end
      if (fatalSysErr && fatalSysCode >= bestCode) begin
         anyEvt = 1'b1;
         bestFatal = 1'b1;
         bestCode = fatalSysCode; // [RULE7]
         bestInfo = 16'h0000;
      end
      if (stopEvt && numCode(`CEL_CODE_STOP_BASE, instrNum) >= bestCode) begin
         anyEvt = 1'b1;
         bestFatal = 1'b1;
         bestCode = numCode(`CEL_CODE_STOP_BASE, instrNum); // [RULE3] [RULE7]
         bestInfo = {7'h00, instrNum};
      end
   end

   // nothing is logged in reset state or after a watchdog failure
   wire logAllowed = ~(state[4] | state[0]) & ~wdogFail & ~resetCause; // [RULE11] [RULE13]
   wire logPush = anyEvt & logAllowed; // [RULE1]
   wire fatalEvt = logPush & bestFatal;
   wire [79:0] logRecord = {
      bestFatal ? `CEL_CAT_FATAL : `CEL_CAT_NONFATAL,
      timeStamp[31:16], timeStamp[15:0], bestInfo, bestCode}; // [RULE23]

   wire [9:0] logOffset = {2'b00, wordAddr} - (`CEL_OFS_LOG >> 2);
   wire [15:0] logRdData;
   wire [4:0] logCount;

   cel_log_store #(
      .RECORDS(`CEL_LOG_RECORDS),
      .WORDS(`CEL_LOG_WORDS)
   ) u_store (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .push(logPush),
      .clearPtr(logPtrRst),
      .record(logRecord),
      .rdIndex(logOffset[6:0]),
      .rdData(logRdData),
      .count(logCount)
   );

   // operating state
   always @* begin
      next_state = state;
      if (state == ST_CPUERR || wdogFail) begin
         next_state = ST_CPUERR; // [RULE11]
      end else if (resetCause) begin
         next_state = ST_RESET; // [RULE14] [RULE15]
      end else begin
         case (state)
            ST_RESET: begin
               next_state = ST_STANDBY; // [RULE16]
            end
            ST_STANDBY: begin
               if (ctrl[`CEL_CTRL_RUN_REQ] && !busUnitStartFail && !specialUnitMissing &&
                   (unitsDetected || setup[`CEL_SETUP_NOWAIT])) begin
                  next_state = ST_RUN; // [RULE17] [RULE18] [RULE19]
               end
            end
            ST_RUN: begin
               if (fatalEvt) begin
                  next_state = ST_FATAL; // [RULE4] [RULE9]
               end else if (!ctrl[`CEL_CTRL_RUN_REQ]) begin
                  next_state = ST_STANDBY;
               end
            end
            ST_FATAL: begin
               if (wrErrClr) begin
                  next_state = ST_STANDBY;
               end
            end
            default: begin
               next_state = ST_STANDBY;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_STANDBY;
         programRun <= 1'b0;
         toolConnectEnable <= 1'b0;
         powerOffIrq <= 1'b0;
         ioMemClear <= 1'b0;
         fatalByStop <= 1'b0;
         outputsForcedOff <= 1'b0;
         timeStamp <= 32'h0;
      end else begin
         state <= next_state;
         timeStamp <= timeStamp + 32'h1;
         programRun <= (next_state == ST_RUN); // [RULE4] [RULE10] [RULE15]
         toolConnectEnable <= !(next_state == ST_CPUERR || next_state == ST_RESET); // [RULE12]
         powerOffIrq <= rackLost && !rackLostPrev && state == ST_RUN &&
                        ctrl[`CEL_CTRL_PWROFF_INT_EN]; // [RULE15]
         ioMemClear <= state != ST_FATAL && next_state == ST_FATAL && !stopEvt &&
                       !ctrl[`CEL_CTRL_IOM_HOLD]; // [RULE22]
         if (state != ST_FATAL && next_state == ST_FATAL) begin
            fatalByStop <= stopEvt;
         end
         outputsForcedOff <= next_state == ST_FATAL && ctrl[`CEL_CTRL_IOM_HOLD] &&
                             !((state == ST_FATAL) ? fatalByStop : stopEvt); // [RULE22]
      end
   end

   // software registers; a new error wins over a clear in the same cycle
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `CEL_CTRL_RST_VAL;
         setup <= `CEL_SETUP_RST_VAL;
         errCode <= 16'h0000;
         nonFatalPend <= 1'b0;
      end else begin
         if (wrCtrl) begin
            ctrl <= ctrlNew[4:0];
         end
         if (wrSetup) begin
            setup <= {avs_byteenable[1] ? avs_writedata[15] : setup[15], 15'h0000}; // [RULE19]
         end
         if (logPush && (bestCode > errCode || wrErrClr)) begin
            errCode <= bestCode; // [RULE7]
         end else if (wrErrClr) begin
            errCode <= 16'h0000;
         end
         if (logPush && !bestFatal) begin
            nonFatalPend <= 1'b1; // [RULE8]
         end else if (wrErrClr) begin
            nonFatalPend <= 1'b0;
         end
      end
   end

   // read mux and wait-state generation
   reg [31:0] rdValue;
   always @* begin
      rdValue = 32'h0;
      case (wordAddr)
         `CEL_OFS_CTRL >> 2: rdValue = {27'h0, ctrl};
         `CEL_OFS_SETUP >> 2: rdValue = {16'h0000, setup};
         `CEL_OFS_ERRCODE >> 2: rdValue = {16'h0000, errCode};
         `CEL_OFS_STATUS >> 2: rdValue = {17'h0, toolConnectEnable, nonFatalPend,
                                          logCount, 3'h0, state};
         default: begin
            if (wordAddr >= (`CEL_OFS_LOG >> 2)) begin
               rdValue = {16'h0000, logRdData};
            end
         end
      endcase
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= ~(busReq & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdValue;
         end
      end
   end

   cel_lamp_ctrl #(
      .BLINK_HALF_CYC(BLINK_HALF_CYC)
   ) u_lamps (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .inRun(state == ST_RUN),
      .inFatal(state == ST_FATAL),
      .inCpuErr(state == ST_CPUERR),
      .inReset(state == ST_RESET),
      .nonFatal(nonFatalPend),
      .outOff(ctrl[`CEL_CTRL_OUT_OFF]),
      .toolCommErr(toolCommErr),
      .serialCommErr(serialCommErr),
      .runLamp(runLamp),
      .errorLamp(errorLamp),
      .outputInhibitLamp(outputInhibitLamp),
      .toolPortLamp(toolPortLamp),
      .serialPortLamp(serialPortLamp)
   );
endmodule // cel_error_log

`default_nettype wire

// File: dv/cel_error_log_props.sv
`timescale 1ns/10ps
`default_nettype none
module cel_error_log_props (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic rackPowerLost,
   input wire logic ioCtrlMiswired,
   input wire logic rackCableReversed,
   input wire logic watchdogExpired,
   input wire logic runLamp,
   input wire logic errorLamp,
   input wire logic outputInhibitLamp,
   input wire logic toolConnectEnable,
   input wire logic programRun,
   input wire logic ioMemClear
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   wire rackDown = rackPowerLost | ioCtrlMiswired | rackCableReversed;
   wire wrDone = avs_write & ~avs_waitrequest & (&avs_byteenable[1:0]) & |avs_writedata[8:0];
   chk_bus_wait: assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
      else $error("long wait");
   chk_stop_halts: assert property (wrDone & avs_address[9:2] == 8'h03 & programRun |-> ##[1:4] !programRun)
      else $error("stop did not halt");
   chk_alarm_runs: assert property (wrDone & avs_address[9:2] == 8'h02 & programRun & !rackDown & !watchdogExpired |=> programRun [*3])
      else $error("alarm halted");
   chk_run_lamp_on: assert property (programRun [*3] |-> runLamp)
      else $error("run lamp dark");
   chk_run_lamp_off: assert property (!programRun [*3] |-> !runLamp)
      else $error("run lamp lit");
   chk_rack_reset: assert property ((rackDown & !watchdogExpired) [*8] |-> !runLamp & !errorLamp & !outputInhibitLamp & !toolConnectEnable & !programRun)
      else $error("reset lamps");
   chk_wdog_stop: assert property ((watchdogExpired & !rackDown) [*8] |-> errorLamp & !runLamp & !toolConnectEnable & !programRun)
      else $error("watchdog lamps");
   chk_fatal_show: assert property ($rose(ioMemClear) |-> ##[1:3] (errorLamp & !runLamp & toolConnectEnable))
      else $error("fatal lamps");
   cov_run: cover property ($rose(programRun));
   cov_clear: cover property ($rose(ioMemClear));
   cov_alarm: cover property (wrDone & avs_address[9:2] == 8'h02);
endmodule // cel_error_log_props
bind cel_error_log cel_error_log_props cel_error_log_props_i (.*);
`default_nettype wire

// File: dv/cel_units_model.sv
`timescale 1ns/10ps
`default_nettype none
module cel_units_model (
   input wire logic clk_sys,
   output logic unitsDetected,
   output logic busUnitStartFail,
   output logic specialUnitMissing,
   output logic busUnitErr,
   output logic specialUnitErr,
   output logic busUnitSetErr,
   output logic specialUnitSetErr,
   output logic batteryErr,
   output logic [7:0] unitNum
);
   initial begin
      {unitsDetected, busUnitStartFail, specialUnitMissing} = 3'h0;
      {busUnitErr, specialUnitErr, busUnitSetErr, specialUnitSetErr, batteryErr} = 5'h00;
      unitNum = 8'hA5;
   end
   task automatic setUnits(input logic det, input logic fail, input logic miss);
      @(posedge clk_sys);
      {unitsDetected, busUnitStartFail, specialUnitMissing} <= {det, fail, miss};
   endtask
   task automatic fire(input logic [4:0] kinds, input logic [7:0] num);
      @(posedge clk_sys);
      {busUnitErr, specialUnitErr, busUnitSetErr, specialUnitSetErr, batteryErr} <= kinds;
      unitNum <= num;
      @(posedge clk_sys);
      {busUnitErr, specialUnitErr, busUnitSetErr, specialUnitSetErr, batteryErr} <= 5'h00;
      unitNum <= ~num;
   endtask
endmodule // cel_units_model
`default_nettype wire

// File: dv/cel_error_log_test.sv
`timescale 1ns/10ps
`default_nettype none
module cel_error_log_test;
   logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic rackPowerLost, ioCtrlMiswired, rackCableReversed, watchdogExpired, fatalSysErr;
   logic unitsDetected, busUnitStartFail, specialUnitMissing, busUnitErr, specialUnitErr;
   logic busUnitSetErr, specialUnitSetErr, batteryErr, toolCommErr, serialCommErr;
   logic [7:0] unitNum;
   logic [15:0] fatalSysCode, modelCode;
   logic runLamp, errorLamp, outputInhibitLamp, toolPortLamp, serialPortLamp;
   logic programRun, toolConnectEnable, powerOffIrq, ioMemClear, outputsForcedOff;
   logic irqSeen, memSeen, nf;
   int num_errors, tests_run, cycles, seed, n, k, j, hi, cnt;
   logic [15:0] logQ[$];
   logic [15:0] catQ[$];
   logic [15:0] bases[5] = '{16'h0200, 16'h0300, 16'h0400, 16'h0500, 16'h00F7};
   cel_error_log #(.BLINK_HALF_CYC(32'h4)) cel_error_log_i (.*);
   cel_units_model cel_units_model_i (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (powerOffIrq === 1'b1) irqSeen = 1'b1;
      if (ioMemClear === 1'b1) memSeen = 1'b1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("counts %0d run %0d bad", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic [7:0] w, input logic [15:0] d);
      @(posedge clk_sys);
      avs_address <= {w, 2'b00};
      avs_writedata <= {16'h0000, d};
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic checkReg(input logic [7:0] w, input logic [31:0] exp);
      xfer(1'b0, w, 16'h0000);
      tests_run++;
      if (rd !== exp) begin
         num_errors++;
         $display("BAD %0t word %h read %h want %h", $time, w, rd, exp);
      end
   endtask
   task automatic checkPin(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t check %0d is %b want %b", $time, tests_run, got, exp);
      end
   endtask
   function automatic logic [31:0] stat(input logic [4:0] st, input logic tool);
      return {17'h0, tool, nf, cnt[4:0], 3'h0, st};
   endfunction
   task automatic logIt(input logic [15:0] code, input logic [15:0] cat);
      logQ.push_front(code);
      catQ.push_front(cat);
      if (logQ.size() > 20) begin
         void'(logQ.pop_back());
         void'(catQ.pop_back());
      end
      if (cnt < 20) cnt++;
      if (code > modelCode) modelCode = code;
      if (cat == 16'h0001) nf = 1'b1;
      checkReg(8'h40, {16'h0000, logQ[0]});
      checkReg(8'h44, {16'h0000, catQ[0]});
   endtask
   task automatic waitRun;
      for (j = 0; j < 60 && programRun !== 1'b1; j++) @(posedge clk_sys);
      checkPin(programRun, 1'b1);
   endtask
   task automatic fatalCase(input logic useStop, input logic hold);
      xfer(1'b1, 8'h00, {12'h000, hold, 3'h1});
      waitRun();
      memSeen = 1'b0;
      n = ($random(seed) & 32'h1FF) | 32'h1;
      if (useStop) xfer(1'b1, 8'h03, n[15:0]);
      else begin
         fatalSysErr <= 1'b1;
         @(posedge clk_sys);
         fatalSysErr <= 1'b0;
      end
      repeat (6) @(posedge clk_sys);
      checkPin(programRun, 1'b0);
      checkPin(errorLamp, 1'b1);
      checkPin(toolConnectEnable, 1'b1);
      checkPin(memSeen, !useStop && !hold);
      checkPin(outputsForcedOff, hold);
      logIt(useStop ? 16'hC100 + n[15:0] : 16'h80F1, 16'h0002);
      checkReg(8'h05, stat(5'h08, 1'b1));
      xfer(1'b1, 8'h04, 16'h0000);
      modelCode = 16'h0000;
      nf = 1'b0;
   endtask
   initial begin
      seed = 32'h672B5B0A;
      {rstn, avs_read, avs_write, rackPowerLost, ioCtrlMiswired, rackCableReversed} = 6'h00;
      {watchdogExpired, fatalSysErr, toolCommErr, serialCommErr, nf} = 5'h00;
      avs_address = 10'h000;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      fatalSysCode = 16'h80F1;
      modelCode = 16'h0000;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      checkReg(8'h05, stat(5'h02, 1'b1));
      checkReg(8'h01, 32'h0);
      checkReg(8'h20, 32'h0);
      xfer(1'b1, 8'h00, 16'h0001);
      repeat (10) @(posedge clk_sys);
      checkPin(programRun, 1'b0);
      checkPin(errorLamp, 1'b0);
      cel_units_model_i.setUnits(1'b0, 1'b1, 1'b1);
      xfer(1'b1, 8'h01, 16'h8000);
      checkReg(8'h05, stat(5'h02, 1'b1));
      cel_units_model_i.setUnits(1'b0, 1'b0, 1'b0);
      waitRun();
      cel_units_model_i.setUnits(1'b1, 1'b0, 1'b0);
      $display("startup test done");
      for (k = 0; k < 6; k++) begin
         n = (k == 0) ? 1 : (k == 1) ? 511 : (($random(seed) & 32'h1FF) | 32'h1);
         xfer(1'b1, 8'h02, n[15:0]);
         logIt(16'h4100 + n[15:0], 16'h0001);
      end
      xfer(1'b1, 8'h02, 16'h0000);
      checkReg(8'h05, stat(5'h04, 1'b1));
      $display("alarm test done");
      for (k = 0; k < 15; k++) begin
         n = $unsigned($random(seed)) % ((k % 5) % 2 == 0 ? 16 : 96);
         cel_units_model_i.fire(5'h10 >> (k % 5), n[7:0]);
         logIt(bases[k % 5] + ((k % 5) < 4 ? n[15:0] : 16'h0), 16'h0001);
      end
      cel_units_model_i.fire(5'h11, 8'h0C);
      logIt(16'h020C, 16'h0001);
      checkReg(8'h04, {16'h0000, modelCode});
      checkReg(8'h05, stat(5'h04, 1'b1));
      for (k = 0; k < 20; k++) checkReg(8'h40 + 5 * k, {16'h0000, logQ[k]});
      $display("log test done");
      for (hi = 0, k = 0; k < 16; k++) @(posedge clk_sys) hi += (errorLamp === 1'b1);
      checkPin(hi > 0 && hi < 16, 1'b1);
      xfer(1'b1, 8'h00, 16'h0005);
      {toolCommErr, serialCommErr} <= 2'b11;
      repeat (6) @(posedge clk_sys);
      checkPin(outputInhibitLamp, 1'b1);
      checkPin(toolPortLamp, 1'b0);
      checkPin(serialPortLamp, 1'b0);
      {toolCommErr, serialCommErr} <= 2'b00;
      xfer(1'b1, 8'h00, 16'h4001);
      cnt = 0;
      checkReg(8'h05, stat(5'h04, 1'b1));
      checkReg(8'h40, {16'h0000, logQ[0]});
      $display("lamp test done");
      for (k = 0; k < 3; k++) fatalCase(k == 0, k == 2);
      $display("fatal test done");
      for (k = 0; k < 3; k++) begin
         xfer(1'b1, 8'h00, 16'h0011);
         waitRun();
         irqSeen = 1'b0;
         {rackCableReversed, ioCtrlMiswired, rackPowerLost} <= 3'b001 << k;
         repeat (8) @(posedge clk_sys);
         checkPin(programRun, 1'b0);
         if (k == 0) checkPin(irqSeen, 1'b1);
         cel_units_model_i.fire(5'h01, 8'h00);
         checkReg(8'h05, stat(5'h01, 1'b0));
         {rackCableReversed, ioCtrlMiswired, rackPowerLost} <= 3'b000;
      end
      waitRun();
      $display("reset test done");
      watchdogExpired <= 1'b1;
      repeat (8) @(posedge clk_sys);
      cel_units_model_i.fire(5'h01, 8'h00);
      checkReg(8'h05, stat(5'h10, 1'b0));
      watchdogExpired <= 1'b0;
      repeat (8) @(posedge clk_sys);
      checkPin(errorLamp, 1'b1);
      checkPin(toolConnectEnable, 1'b0);
      $display("watchdog test done");
      wrap_up();
   end
endmodule // cel_error_log_test
`default_nettype wire
